/* File: design/wkd_filter.sv */
/*
 * One wake pin channel: two-flop synchroniser, edge detect and deglitch counter.
 * Assumes the gate input is stable; pin is asynchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module wkd_filter #(
    parameter int CNT_W = 10
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PIN,
    input wire logic ACTIVE,
    input wire logic [CNT_W-1:0] LIMIT,
    output logic LEVEL,
    output logic EVENT
);
    logic meta_reg;
    logic sync_reg;
    logic stable_reg;
    logic run_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic event_reg;

    wire crossed = sync_reg != stable_reg;
    wire expired = run_reg && (cnt_reg + 1'b1 >= LIMIT);

    // Synchroniser first stage feeds only the second stage
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= PIN;
            sync_reg <= meta_reg;
        end
    end

    // Any crossing starts the timer; crossing back aborts it
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            stable_reg <= 1'b0;
            run_reg <= 1'b0;
            cnt_reg <= '0;
            event_reg <= 1'b0;
        end else begin
            event_reg <= 1'b0;
            if (!ACTIVE) begin
                run_reg <= 1'b0;
                cnt_reg <= '0;
            end else if (!run_reg && crossed) begin
                run_reg <= 1'b1;
                cnt_reg <= '0;
            end else if (run_reg && !crossed) begin
                run_reg <= 1'b0;
            end else if (expired) begin
                run_reg <= 1'b0;
                stable_reg <= sync_reg;
                event_reg <= 1'b1;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign LEVEL = stable_reg;
    assign EVENT = event_reg;

    property p_filter_hold;
        @(posedge CLOCK) disable iff (!RSTN)
        event_reg |-> $past(run_reg, 2);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("event without running filter");
endmodule
`default_nettype wire

/* File: design/wkd_pkg.sv */
/*
 * Package of the wake input detector: register map, field layout, filter timing and carriers.
 * Assumes a 10 MHz core clock and 32-bit APB register access.
 */
package wkd_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SHORT_FILTER_TIME_US = 16;
    localparam int LONG_FILTER_TIME_US = 64;
    localparam int SHORT_FILTER_CYC = (SHORT_FILTER_TIME_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int LONG_FILTER_CYC = (LONG_FILTER_TIME_US * CLK_HZ + 999_999) / 1_000_000;

    // Register byte offsets
    localparam logic [7:0] OFS_WAKE_ENABLE = 8'h00;
    localparam logic [7:0] OFS_SOURCE_STAT = 8'h04;
    localparam logic [7:0] OFS_ALT_STAT = 8'h08;
    localparam logic [7:0] OFS_LEVEL_STAT = 8'h0c;
    localparam logic [7:0] OFS_BIAS_CFG = 8'h10;
    localparam logic [7:0] OFS_DETECT_CFG = 8'h14;
    localparam logic [7:0] OFS_MEAS_CTRL = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

    // Field positions
    localparam int MEAS_EN_BIT = 0;
    localparam int ALT_WAKE_BIT = 1;
    localparam int SLEEP_FAIL_BIT = 2;

    // Reset values
    localparam logic [2:0] WAKE_ENABLE_RST = 3'h0;
    localparam logic [5:0] BIAS_CFG_RST = 6'h00;
    localparam logic [5:0] DETECT_CFG_RST = 6'h00;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;

    // Detection field codes
    localparam logic [1:0] DET_STATIC_SHORT = 2'h0;
    localparam logic [1:0] DET_STATIC_LONG = 2'h1;
    localparam logic [1:0] DET_CYCLIC_A = 2'h2;
    localparam logic [1:0] DET_CYCLIC_B = 2'h3;

    // Bias field codes
    localparam logic [1:0] BIAS_NONE = 2'h0;
    localparam logic [1:0] BIAS_DOWN = 2'h1;
    localparam logic [1:0] BIAS_UP = 2'h2;
    localparam logic [1:0] BIAS_AUTO = 2'h3;

    typedef enum logic [1:0] {
        WKD_NORMAL,
        WKD_STOP,
        WKD_SLEEP,
        WKD_FAILSAFE
    } wkd_mode_e;

    typedef struct packed {
        logic [2:0] pull_up;
        logic [2:0] pull_down;
    } wkd_bias_s;
endpackage

/* File: design/wkd_top.sv */
/*
 * Wake input detector top: three wake pins, two alternate wake inputs, APB registers,
 * bias control, measurement switch gating, sticky status with one interrupt.
 * Assumes mode, cyclic windows and sleep requests come from the device state machine.
 */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module wkd_top
    import wkd_pkg::*;
#(
    parameter int NUM_PINS = 3,
    parameter int NUM_ALT = 2
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NUM_PINS-1:0] WAKE_PIN,
    input wire logic [NUM_ALT-1:0] FAIL_OUTPUTS_ALT_WAKE,
    input wire wkd_pkg::wkd_mode_e MODE,
    input wire logic [1:0] CYCLIC_WINDOW,
    input wire logic SLEEP_REQUEST,
    output wkd_pkg::wkd_bias_s BIAS,
    output logic MEASURE_SWITCH,
    output logic WAKE_UP,
    output logic RESTART_REQUEST,
    output logic IRQ
);
    import wkd_pkg::*;

    localparam int CNT_W = 10;
    localparam int NSTAT = NUM_PINS + NUM_ALT;

    initial begin
        if (NUM_PINS != 3 || NUM_ALT != 2) begin
            $error("wkd_top supports exactly three wake pins and two alternate inputs");
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] wake_enable_reg;
    logic [5:0] bias_current_config_reg;
    logic [5:0] detect_filter_config_reg;
    logic [1:0] meas_ctrl_reg;
    logic sleep_fail_reg;
    logic [NUM_PINS-1:0] wake_source_status_reg;
    logic [NUM_ALT-1:0] alt_wake_source_status_reg;
    logic [NUM_PINS-1:0] pin_level_status_reg;
    logic [NSTAT-1:0] irq_mask_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    wkd_bias_s bias_reg;
    logic meas_switch_reg;
    logic wake_up_reg;
    logic restart_reg;
    logic irq_reg;

    function automatic logic [1:0] field2(input logic [5:0] v, input int idx);
        field2 = v[2*idx +: 2];
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup = PSEL && !PENABLE;
    wire access = PSEL && PENABLE && pready_reg;
    wire wr = access && PWRITE;
    wire addr_ok = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_IRQ_MASK);
    wire wr_en = wr && addr_ok && PADDR == OFS_WAKE_ENABLE;
    wire wr_src = wr && addr_ok && PADDR == OFS_SOURCE_STAT;
    wire wr_alt = wr && addr_ok && PADDR == OFS_ALT_STAT;
    wire wr_bias = wr && addr_ok && PADDR == OFS_BIAS_CFG;
    wire wr_det = wr && addr_ok && PADDR == OFS_DETECT_CFG;
    wire wr_meas = wr && addr_ok && PADDR == OFS_MEAS_CTRL;
    wire wr_mask = wr && addr_ok && PADDR == OFS_IRQ_MASK;

    wire meas_on = meas_ctrl_reg[MEAS_EN_BIT];
    wire alt_on = meas_ctrl_reg[ALT_WAKE_BIT];
    wire normal_mode = MODE == WKD_NORMAL;
    wire level_mode = MODE == WKD_NORMAL || MODE == WKD_STOP;

    // ------------------------------------------------------------
    // Per-pin channels
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pin_event;
    logic [NUM_PINS-1:0] pin_gated;
    logic [NUM_PINS-1:0] pin_active;
    logic [NUM_PINS-1:0] pin_cyclic;
    logic [NUM_ALT-1:0] alt_event;
    logic [NUM_PINS-1:0] bias_up_next;
    logic [NUM_PINS-1:0] bias_down_next;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            wire [1:0] det = field2(detect_filter_config_reg, g);
            wire [1:0] bsel = field2(bias_current_config_reg, g);
            wire [CNT_W-1:0] limit = (det == DET_STATIC_LONG) ? CNT_W'(LONG_FILTER_CYC)
                                                                : CNT_W'(SHORT_FILTER_CYC);
            assign pin_gated[g] = (g < 2) && meas_on;
            assign pin_cyclic[g] = det[1];
            assign pin_active[g] = !pin_gated[g] &&
                (!det[1] || (det[0] ? CYCLIC_WINDOW[1] : CYCLIC_WINDOW[0]));
            assign bias_up_next[g] = !pin_gated[g] &&
                (bsel == BIAS_UP || (bsel == BIAS_AUTO && pin_level[g]));
            assign bias_down_next[g] = !pin_gated[g] &&
                (bsel == BIAS_DOWN || (bsel == BIAS_AUTO && !pin_level[g]));
            wkd_filter #(.CNT_W(CNT_W)) u_filt (
                .CLOCK(CLOCK),
                .RSTN(RSTN),
                .PIN(WAKE_PIN[g]),
                .ACTIVE(pin_active[g]),
                .LIMIT(limit),
                .LEVEL(pin_level[g]),
                .EVENT(pin_event[g])
            );
        end
        for (g = 0; g < NUM_ALT; g++) begin : g_alt
            wkd_filter #(.CNT_W(CNT_W)) u_filt (
                .CLOCK(CLOCK),
                .RSTN(RSTN),
                .PIN(FAIL_OUTPUTS_ALT_WAKE[g]),
                .ACTIVE(alt_on),
                .LIMIT(CNT_W'(SHORT_FILTER_CYC)),
                .LEVEL(),
                .EVENT(alt_event[g])
            );
        end
    endgenerate

    // Only enabled, ungated pins count as wake sources
    wire [NUM_PINS-1:0] src_set = pin_event & wake_enable_reg & ~pin_gated;
    wire [NUM_ALT-1:0] alt_set = alt_event;
    wire [NSTAT-1:0] status_all = {alt_wake_source_status_reg, wake_source_status_reg};
    wire any_wake = |src_set || |alt_set;
    wire low_power = MODE == WKD_SLEEP || MODE == WKD_FAILSAFE;
    wire only12 = meas_on && (wake_enable_reg[2] == 1'b0) && |wake_enable_reg[1:0] && !alt_on;
    wire sleep_fail = SLEEP_REQUEST && only12;

    // Level shown live in static sense in normal and stop modes; cyclic keeps the last in-window sample
    wire [NUM_PINS-1:0] lvl_upd = {NUM_PINS{level_mode}} & ~pin_gated & (~pin_cyclic | pin_active);

    // ------------------------------------------------------------
    // Register writes and status
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wake_enable_reg <= WAKE_ENABLE_RST;
            bias_current_config_reg <= BIAS_CFG_RST;
            detect_filter_config_reg <= DETECT_CFG_RST;
            meas_ctrl_reg <= 2'h0;
            irq_mask_reg <= IRQ_MASK_RST;
        end else begin
            // Settings of gated pins are still stored
            if (wr_en) wake_enable_reg <= PWDATA[NUM_PINS-1:0];
            if (wr_bias) bias_current_config_reg <= PWDATA[5:0];
            if (wr_det) detect_filter_config_reg <= PWDATA[5:0];
            if (wr_meas) meas_ctrl_reg <= PWDATA[1:0];
            if (wr_mask) irq_mask_reg <= PWDATA[NSTAT-1:0];
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wake_source_status_reg <= '0;
            alt_wake_source_status_reg <= '0;
            sleep_fail_reg <= 1'b0;
            pin_level_status_reg <= '0;
        end else begin
            wake_source_status_reg <= (wake_source_status_reg &
                ~(wr_src ? PWDATA[NUM_PINS-1:0] : '0)) | src_set;
            alt_wake_source_status_reg <= (alt_wake_source_status_reg &
                ~(wr_alt ? PWDATA[NUM_ALT-1:0] : '0)) | alt_set;
            sleep_fail_reg <= (sleep_fail_reg &
                ~(wr_meas && PWDATA[SLEEP_FAIL_BIT])) | sleep_fail;
            pin_level_status_reg <= (pin_level_status_reg & ~lvl_upd) | (pin_level & lvl_upd);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bias_reg <= '0;
            meas_switch_reg <= 1'b0;
            wake_up_reg <= 1'b0;
            restart_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            bias_reg <= '{pull_up: bias_up_next, pull_down: bias_down_next};
            meas_switch_reg <= meas_on && normal_mode;
            wake_up_reg <= any_wake && low_power;
            restart_reg <= sleep_fail;
            // A set mask bit hides its status bit from the interrupt line
            irq_reg <= |(status_all & ~irq_mask_reg) && !low_power;
        end
    end

    // ------------------------------------------------------------
    // APB answer: no wait state, error on unmapped address
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (PADDR)
            OFS_WAKE_ENABLE: rd_mux[NUM_PINS-1:0] = wake_enable_reg;
            OFS_SOURCE_STAT: rd_mux[NUM_PINS-1:0] = wake_source_status_reg;
            OFS_ALT_STAT: rd_mux[NUM_ALT-1:0] = alt_wake_source_status_reg;
            OFS_LEVEL_STAT: rd_mux[NUM_PINS-1:0] = pin_level_status_reg;
            OFS_BIAS_CFG: rd_mux[5:0] = bias_current_config_reg;
            OFS_DETECT_CFG: rd_mux[5:0] = detect_filter_config_reg;
            OFS_MEAS_CTRL: rd_mux[2:0] = {sleep_fail_reg, meas_ctrl_reg};
            OFS_IRQ_MASK: rd_mux[NSTAT-1:0] = irq_mask_reg;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !addr_ok;
            prdata_reg <= (setup && addr_ok && !PWRITE) ? rd_mux : 32'h0;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign BIAS = bias_reg;
    assign MEASURE_SWITCH = meas_switch_reg;
    assign WAKE_UP = wake_up_reg;
    assign RESTART_REQUEST = restart_reg;
    assign IRQ = irq_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_switch_normal;
        @(posedge CLOCK) disable iff (!RSTN)
        MEASURE_SWITCH |-> $past(MODE) == WKD_NORMAL && $past(meas_on);
    endproperty
    a_switch_normal: assert property (p_switch_normal) else $error("switch closed outside normal");

    property p_switch_closes;
        @(posedge CLOCK) disable iff (!RSTN)
        (meas_on && normal_mode) |=> MEASURE_SWITCH;
    endproperty
    a_switch_closes: assert property (p_switch_closes) else $error("switch failed to close");

    property p_gated_bias;
        @(posedge CLOCK) disable iff (!RSTN)
        meas_on |=> (BIAS.pull_up[1:0] == 2'h0 && BIAS.pull_down[1:0] == 2'h0);
    endproperty
    a_gated_bias: assert property (p_gated_bias) else $error("bias active on measured pins");

    property p_gated_status;
        @(posedge CLOCK) disable iff (!RSTN)
        (meas_on && !wr_src) |=> wake_source_status_reg[1:0] == $past(wake_source_status_reg[1:0]);
    endproperty
    a_gated_status: assert property (p_gated_status) else $error("gated pin status moved");

    property p_source_set;
        @(posedge CLOCK) disable iff (!RSTN)
        (pin_event[2] && wake_enable_reg[2]) |=> wake_source_status_reg[2];
    endproperty
    a_source_set: assert property (p_source_set) else $error("wake source not recorded");

    property p_disabled_pin;
        @(posedge CLOCK) disable iff (!RSTN)
        (!wake_enable_reg[2] && !wake_source_status_reg[2]) |=> !wake_source_status_reg[2];
    endproperty
    a_disabled_pin: assert property (p_disabled_pin) else $error("disabled pin woke device");

    property p_wake_low_power;
        @(posedge CLOCK) disable iff (!RSTN)
        WAKE_UP |-> $past(low_power) && $past(any_wake);
    endproperty
    a_wake_low_power: assert property (p_wake_low_power) else $error("wake outside sleep or fail-safe");

    property p_sleep_fail;
        @(posedge CLOCK) disable iff (!RSTN)
        sleep_fail |=> RESTART_REQUEST && sleep_fail_reg;
    endproperty
    a_sleep_fail: assert property (p_sleep_fail) else $error("sleep failure not flagged");

    property p_auto_bias;
        @(posedge CLOCK) disable iff (!RSTN)
        (field2(bias_current_config_reg, 2) == BIAS_AUTO) |=> BIAS.pull_up[2] == $past(pin_level[2]);
    endproperty
    a_auto_bias: assert property (p_auto_bias) else $error("auto bias mismatch");
endmodule
`default_nettype wire

/* File: tb/wkd_pin_driver.sv */
/*
 * Model of the switches and sense circuits on the wake and alternate wake pins.
 * Assumes the bench calls its tasks from a process tied to the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module wkd_pin_driver (
    input wire logic clock,
    output logic [2:0] wake_pin,
    output logic [1:0] alt_pin
);
    logic [4:0] level_reg = 5'h00;
    assign wake_pin = level_reg[2:0];
    assign alt_pin = level_reg[4:3];
    // A switch drives hard, so the pin keeps its level with no release phase
    task automatic set_pin(input int idx, input logic val);
        @(posedge clock);
        level_reg[idx] <= val;
    endtask
    // Bounce shorter than the filter, to exercise the abort path
    task automatic glitch(input int idx, input int cyc);
        set_pin(idx, ~level_reg[idx]);
        repeat (cyc) @(posedge clock);
        level_reg[idx] <= ~level_reg[idx];
    endtask
endmodule
`default_nettype wire

/* File: tb/wkd_top_bench.sv */
/*
 * Self-checking bench of the wake input detector over APB.
 * Assumes wkd_pkg, wkd_top and wkd_pin_driver are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module wkd_top_bench;
    import wkd_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] wake_pin;
    logic [1:0] alt_pin;
    wkd_mode_e mode = WKD_NORMAL;
    logic [1:0] cyc_win = 2'h0;
    logic sleep_req = 1'b0;
    wkd_bias_s bias;
    logic meas_sw;
    logic wake_up;
    logic restart_req;
    logic irq;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // Clock, instances, timeout
    // ------------------------------------------------------------
    initial begin
        forever #50 clock = ~clock;
    end
    wkd_top wkd_top_i (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .WAKE_PIN(wake_pin), .FAIL_OUTPUTS_ALT_WAKE(alt_pin), .MODE(mode), .CYCLIC_WINDOW(cyc_win),
        .SLEEP_REQUEST(sleep_req), .BIAS(bias), .MEASURE_SWITCH(meas_sw), .WAKE_UP(wake_up),
        .RESTART_REQUEST(restart_req), .IRQ(irq));
    wkd_pin_driver wkd_pin_driver_i (.clock(clock), .wake_pin(wake_pin), .alt_pin(alt_pin));
    // Whole run is about 4000 cycles; the ceiling leaves wide margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pin(input int i, input logic v);
        wkd_pin_driver_i.set_pin(i, v);
    endtask
    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // No wait state count is assumed; only the cycle ceiling ends a hung access
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, q, exp);
    endtask
    // Status must stay clear before the filter time and be set after it
    task automatic filt(input int i, input logic v, input int lo, input int hi, input logic [7:0] a,
        input logic [31:0] exp);
        pin(i, v);
        cyc(lo);
        rd("early", a, 32'h0);
        cyc(hi - lo);
        rd("late", a, exp);
    endtask
    task automatic irq_is(input logic v);
        cyc(3);
        chk("irq", {31'h0, irq}, {31'h0, v});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd("bias cfg", OFS_BIAS_CFG, 32'h0);
        rd("detect cfg", OFS_DETECT_CFG, 32'h0);
        rd("level", OFS_LEVEL_STAT, 32'h0);
        chk("bias out", {26'h0, bias}, 32'h0);
        apb(1'b1, 8'h20, 32'hffff_ffff, q, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h02, 32'h0, q, e);
        chk("misaligned", {31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_static();
        wr(OFS_WAKE_ENABLE, 32'h7);
        wr(OFS_IRQ_MASK, 32'h0);
        wkd_pin_driver_i.glitch(0, 100);
        cyc(200);
        rd("glitch", OFS_SOURCE_STAT, 32'h0);
        filt(0, 1'b1, 140, 180, OFS_SOURCE_STAT, 32'h1);
        irq_is(1'b1);
        rd("level hi", OFS_LEVEL_STAT, 32'h1);
        wr(OFS_IRQ_MASK, 32'h1f);
        irq_is(1'b0);
        wr(OFS_SOURCE_STAT, 32'h1);
        rd("w1c", OFS_SOURCE_STAT, 32'h0);
        filt(0, 1'b0, 140, 180, OFS_SOURCE_STAT, 32'h1);
        wr(OFS_SOURCE_STAT, 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        wr(OFS_DETECT_CFG, 32'h10);
        filt(2, 1'b1, 600, 690, OFS_SOURCE_STAT, 32'h4);
        wr(OFS_SOURCE_STAT, 32'h4);
        $display("test static done");
    endtask
    task automatic t_cyclic();
        for (int k = 0; k < 2; k++) begin
            wr(OFS_DETECT_CFG, k ? 32'h30 : 32'h20);
            pin(2, k[0]);
            cyc(300);
            rd("no window", OFS_SOURCE_STAT, 32'h0);
            rd("held level", OFS_LEVEL_STAT, {29'h0, ~k[0], 2'h0});
            // The sense supply runs on the same timer as the detect field
            cyc_win <= k ? 2'b10 : 2'b01;
            cyc(250);
            cyc_win <= 2'b00;
            rd("window", OFS_SOURCE_STAT, 32'h4);
            rd("sampled", OFS_LEVEL_STAT, {29'h0, k[0], 2'h0});
            wr(OFS_SOURCE_STAT, 32'h4);
        end
        wr(OFS_DETECT_CFG, 32'h0);
        $display("test cyclic done");
    endtask
    task automatic t_sleep();
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            mode <= k ? WKD_FAILSAFE : WKD_SLEEP;
            pin(2, k[0]);
            repeat (250) begin
                @(posedge clock);
                if (wake_up === 1'b1) n++;
            end
            chk("wake pulses", n, 1);
            chk("irq sleep", {31'h0, irq}, 32'h0);
            rd("sleep src", OFS_SOURCE_STAT, 32'h4);
            wr(OFS_SOURCE_STAT, 32'h4);
        end
        mode <= WKD_NORMAL;
        $display("test sleep done");
    endtask
    task automatic t_bias();
        wr(OFS_BIAS_CFG, 32'h39);
        cyc(5);
        chk("bias hi", {26'h0, bias}, {26'h0, 3'b110, 3'b001});
        pin(2, 1'b0);
        cyc(200);
        chk("bias lo", {26'h0, bias}, {26'h0, 3'b010, 3'b101});
        wr(OFS_SOURCE_STAT, 32'h7);
        $display("test bias done");
    endtask
    task automatic t_meas();
        int n;
        n = 0;
        wr(OFS_MEAS_CTRL, 32'h1);
        cyc(3);
        chk("switch", {31'h0, meas_sw}, 32'h1);
        chk("bias off", {26'h0, bias}, {26'h0, 3'b000, 3'b100});
        mode <= WKD_STOP;
        cyc(3);
        chk("switch stop", {31'h0, meas_sw}, 32'h0);
        mode <= WKD_NORMAL;
        pin(0, 1'b1);
        cyc(250);
        rd("gated src", OFS_SOURCE_STAT, 32'h0);
        rd("gated lvl", OFS_LEVEL_STAT, 32'h0);
        wr(OFS_WAKE_ENABLE, 32'h3);
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        repeat (10) begin
            @(posedge clock);
            if (restart_req === 1'b1) n++;
        end
        chk("restart", n, 1);
        rd("fail flag", OFS_MEAS_CTRL, 32'h5);
        wr(OFS_MEAS_CTRL, 32'h4);
        rd("flag clr", OFS_MEAS_CTRL, 32'h0);
        pin(0, 1'b0);
        cyc(200);
        wr(OFS_SOURCE_STAT, 32'h7);
        wr(OFS_WAKE_ENABLE, 32'h7);
        wr(OFS_MEAS_CTRL, 32'h2);
        filt(3, 1'b1, 140, 180, OFS_ALT_STAT, 32'h1);
        irq_is(1'b1);
        $display("test measure done");
    endtask
    initial begin
        cyc(6);
        rstn <= 1'b1;
        t_reset();
        t_static();
        t_cyclic();
        t_sleep();
        t_bias();
        t_meas();
        results();
    end
endmodule
`default_nettype wire
